// ===== hdl/rsbad_pkg.sv
// Package of constants for the reset, strap, boot and address decode block
package rsbad_pkg;
    // ****************************************
    // Timing
    // ****************************************
    // Strap settle window before external reset release, in cycles
    localparam int STRAP_WINDOW_CYCLES = 10;
    // Width of the strap window counter
    localparam int STRAP_CNT_W = 4;
    // Reset synchroniser depth
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Address map
    // ****************************************
    localparam int ADDR_W = 32;
    // Top of internal memory space (first 4 MB)
    localparam logic [31:0] INT_MEM_LIMIT = 32'h0040_0000;
    // Base of internal peripheral space (last 4 MB)
    localparam logic [31:0] PERIPH_BASE = 32'hFFC0_0000;
    // Internal SRAM size in bytes (8 KB)
    localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;
    // SRAM word count and index width
    localparam int SRAM_WORDS = 2048;
    localparam int SRAM_IDX_W = 11;
    // Base of SRAM alias, decoded whether or not remapped
    localparam logic [31:0] SRAM_ALT_BASE = 32'h0030_0000;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic BOOT_WIDTH_RST = 1'b1;
    localparam logic FLOAT_MODE_RST = 1'b0;
    localparam logic REMAP_RST = 1'b0;
    localparam logic DEBUG_ICE_RST = 1'b1;

    // ****************************************
    // Types
    // ****************************************
    // Decoded region of an access
    typedef enum logic [1:0] {
        RSBAD_REG_MEM = 2'b00,
        RSBAD_REG_EXT = 2'b01,
        RSBAD_REG_PER = 2'b11
    } rsbad_region_type;

    // Boot memory width on the boot chip select
    typedef enum logic {
        RSBAD_BOOT_16 = 1'b0,
        RSBAD_BOOT_8 = 1'b1
    } rsbad_boot_type;

    // Reset sequencer states, Gray coded
    typedef enum logic [1:0] {
        RSBAD_ST_HOLD = 2'b00,
        RSBAD_ST_SYNC = 2'b01,
        RSBAD_ST_RUN = 2'b11
    } rsbad_state_type;
endpackage

// ===== hdl/rsbad_reset_sync.sv
// Asynchronous assert, synchronous release reset synchroniser
`timescale 1ns/100ps
`default_nettype none
module rsbad_reset_sync (
    // Clock
    input wire logic mclk,
    // Asynchronous active-low reset source
    input wire logic arst_n,
    // Synchronised active-low reset
    output logic srst_n
);
    // ****************************************
    // Two stage release chain
    // ****************************************
    // Chain of flops cleared at once on reset
    logic [rsbad_pkg::SYNC_STAGES-1:0] chain_q;

    // Clear instantly, shift ones in on release
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[rsbad_pkg::SYNC_STAGES-2:0], 1'b1};
        end
    end

    // Last stage only is used
    assign srst_n = chain_q[rsbad_pkg::SYNC_STAGES-1];
endmodule
`default_nettype wire

// ===== hdl/rsbad_addr_decode.sv
// Top-level address map decoder
`timescale 1ns/100ps
`default_nettype none
module rsbad_addr_decode (
    // Access address
    input wire logic [31:0] addr,
    // Remap state
    input wire logic remapped,
    // Decoded region
    output rsbad_pkg::rsbad_region_type region,
    // Hit in internal SRAM
    output logic sram_hit,
    // Hit in boot memory on the boot chip select
    output logic boot_hit
);
    // ****************************************
    // Region and memory selection
    // ****************************************
    // Low memory window holds SRAM after remap, boot memory before
    logic in_low;
    logic in_alt;

    always_comb begin
        in_low = addr < rsbad_pkg::SRAM_BYTES;
        in_alt = (addr >= rsbad_pkg::SRAM_ALT_BASE) &&
                 (addr < rsbad_pkg::SRAM_ALT_BASE + rsbad_pkg::SRAM_BYTES);
        // Three spaces: low 4 MB, high 4 MB, EBI between
        if (addr < rsbad_pkg::INT_MEM_LIMIT) begin
            region = rsbad_pkg::RSBAD_REG_MEM;
        end else if (addr >= rsbad_pkg::PERIPH_BASE) begin
            region = rsbad_pkg::RSBAD_REG_PER;
        end else begin
            region = rsbad_pkg::RSBAD_REG_EXT;
        end
        // SRAM at zero only once remapped
        sram_hit = (remapped && in_low) || in_alt;
        // Boot memory at zero before the remap
        boot_hit = !remapped && in_low;
    end
endmodule
`default_nettype wire

// ===== hdl/rsbad_top.sv
// Reset, strap sampling, debug select and address decode top
`timescale 1ns/100ps
`default_nettype none
module rsbad_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Board reset and watchdog reset request
    input wire logic external_reset_n,
    input wire logic watchdog_reset,
    // Strap pins, shared with port lines
    input wire logic boot_width_strap,
    input wire logic output_float_strap,
    // Debug port selection and test logic reset
    input wire logic debug_port_select,
    input wire logic test_logic_reset_n,
    // Remap command bit write strobe
    input wire logic remap_command_bit,
    // Pad drive requests from the shared port lines
    input wire logic port_a_line_18_oe_req,
    input wire logic serial1_transmit_oe_req,
    input wire logic port_b_line_18_oe_req,
    input wire logic [31:0] pad_oe_req,
    // Internal memory access port
    input wire logic [31:0] addr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    // Chip reset outputs
    output logic sys_reset_n,
    output logic core_fetch_zero,
    // Latched strap modes
    output logic boot_8bit,
    output logic float_mode,
    // Debug mode
    output logic debug_ice_mode,
    output logic scan_has_idcode,
    // Pad enables after float gating
    output logic port_a_line_18_oe,
    output logic serial1_transmit_oe,
    output logic port_b_line_18_oe,
    output logic [31:0] pad_oe,
    // Peripheral I/O direction default, high means input
    output logic pio_input_default,
    // Remap status and decode
    output logic remapped,
    output rsbad_pkg::rsbad_region_type region,
    output logic boot_chip_select,
    output logic sram_sel,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    // Every check below samples on the clock and idles in block reset
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************************************
    // Reset sources
    // ****************************************
    // Synchronised external reset, async entry
    logic ext_srst_n;
    // Synchronised merged reset including watchdog
    logic chip_srst_n;
    // Async source for the chip reset
    logic chip_arst_n;

    // External pin or block reset drives external domain
    logic ext_arst_n;
    assign ext_arst_n = external_reset_n && !rst;

    rsbad_reset_sync u_ext_sync (
        .mclk(mclk),
        .arst_n(ext_arst_n),
        .srst_n(ext_srst_n)
    );

    // Watchdog drives the chip reset like the external reset
    assign chip_arst_n = ext_arst_n && !watchdog_reset;

    rsbad_reset_sync u_chip_sync (
        .mclk(mclk),
        .arst_n(chip_arst_n),
        .srst_n(chip_srst_n)
    );

    // Whole chip reset drives defaults
    assign sys_reset_n = chip_srst_n;
    // Fetch from zero; other core state left undefined
    assign core_fetch_zero = !chip_srst_n;
    // All peripheral lines inputs during reset
    assign pio_input_default = !chip_srst_n;

    // ****************************************
    // Strap window tracking
    // ****************************************
    // Cycles for which the float strap has stayed low while in reset
    logic [rsbad_pkg::STRAP_CNT_W-1:0] float_low_q;
    logic [rsbad_pkg::STRAP_CNT_W-1:0] float_low_d;
    // Previous synced state for release edge detect
    logic ext_srst_prev_q;
    // One-cycle pulse at release of external reset
    logic ext_release;

    assign ext_release = ext_srst_n && !ext_srst_prev_q;

    // Saturating count of low float strap cycles
    always_comb begin
        float_low_d = float_low_q;
        if (output_float_strap) begin
            float_low_d = '0;
        end else if (float_low_q != rsbad_pkg::STRAP_CNT_W'(
                     rsbad_pkg::STRAP_WINDOW_CYCLES)) begin
            float_low_d = float_low_q + 1'b1;
        end
    end

    // Count low cycles while external reset held
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            float_low_q <= '0;
        end else begin
            float_low_q <= ext_srst_n ? '0 : float_low_d;
        end
    end

    // Release edge detector on the synchronised reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_srst_prev_q <= 1'b0;
        end else begin
            ext_srst_prev_q <= ext_srst_n;
        end
    end

    // ****************************************
    // Strap latches
    // ****************************************
    // Latched boot width and float mode
    logic boot_8bit_q;
    logic float_mode_q;

    // Latch only at external release, not watchdog
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_8bit_q <= rsbad_pkg::BOOT_WIDTH_RST;
            float_mode_q <= rsbad_pkg::FLOAT_MODE_RST;
        end else if (ext_release) begin
            // External release resamples, watchdog never
            // One selects 8-bit, zero 16-bit
            boot_8bit_q <= boot_width_strap;
            // Low for the final window enters float
            float_mode_q <= (float_low_d == rsbad_pkg::STRAP_CNT_W'(
                             rsbad_pkg::STRAP_WINDOW_CYCLES));
        end
    end

    assign boot_8bit = boot_8bit_q;
    assign float_mode = float_mode_q;

    // ****************************************
    // Output driver gating
    // ****************************************
    // Float mode kills every driver, shared lines too
    always_comb begin
        pad_oe = float_mode_q ? 32'h0000_0000 : pad_oe_req;
        // Shared strap pins act as port lines after reset
        port_a_line_18_oe = !float_mode_q && chip_srst_n &&
                            port_a_line_18_oe_req;
        serial1_transmit_oe = !float_mode_q && chip_srst_n &&
                              serial1_transmit_oe_req;
        // Boot strap pin is a plain port line later
        port_b_line_18_oe = !float_mode_q && chip_srst_n &&
                            port_b_line_18_oe_req;
    end

    // ****************************************
    // Debug port mode
    // ****************************************
    // Debug mode register
    logic debug_ice_q;

    // Select sampled only at full chip reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            debug_ice_q <= rsbad_pkg::DEBUG_ICE_RST;
        end else if (!ext_srst_n && !test_logic_reset_n) begin
            // Low selects emulation, high boundary scan
            debug_ice_q <= !debug_port_select;
        end
    end

    assign debug_ice_mode = debug_ice_q;
    // No id register in scan mode; core id in ICE
    assign scan_has_idcode = 1'b0;

    // ****************************************
    // Remap control
    // ****************************************
    // Remap state
    logic remap_q;

    // Set by command; only the chip reset clears it
    always_ff @(posedge mclk or negedge chip_srst_n) begin
        if (!chip_srst_n) begin
            remap_q <= rsbad_pkg::REMAP_RST;
        end else if (remap_command_bit) begin
            remap_q <= 1'b1;
        end
    end

    assign remapped = remap_q;

    // ****************************************
    // Address decode
    // ****************************************
    // Decoder outputs
    logic sram_hit;
    logic boot_hit;

    rsbad_addr_decode u_dec (
        .addr(addr),
        .remapped(remap_q),
        .region(region),
        .sram_hit(sram_hit),
        .boot_hit(boot_hit)
    );

    assign sram_sel = sram_hit && mem_req;
    // Boot chip select is active low
    assign boot_chip_select = !(boot_hit && mem_req);

    // ****************************************
    // Internal SRAM
    // ****************************************
    // Word read from the four byte-lane columns
    logic [31:0] sram_word;
    // Word index
    logic [rsbad_pkg::SRAM_IDX_W-1:0] sram_idx;
    // Read data and ack registers
    logic [31:0] rdata_q;
    logic ack_q;

    assign sram_idx = addr[rsbad_pkg::SRAM_IDX_W+1:2];

    // Byte lanes little-endian: lane 0 at lowest byte
    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            logic [7:0] lane_mem [rsbad_pkg::SRAM_WORDS]; // Byte column
            assign sram_word[8*b +: 8] = lane_mem[sram_idx];
            always_ff @(posedge mclk) begin
                if (sram_sel && mem_we && mem_be[b]) begin
                    lane_mem[sram_idx] <= mem_wdata[8*b +: 8];
                end
            end
        end
    endgenerate

    // Any size completes in one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            ack_q <= sram_sel;
            rdata_q <= sram_sel ? sram_word : 32'h0000_0000;
        end
    end

    assign mem_rdata = rdata_q;
    assign mem_ack = ack_q;

    // ****************************************
    // Checks
    // ****************************************
    // Release of reset follows two clocked stages
    sequence ext_rel_s;
        $rose(external_reset_n) && !rst ##1 external_reset_n [*2];
    endsequence

    reset_entry_a: assert property (
        !external_reset_n |-> !sys_reset_n)
        else $error("chip reset not asserted by pin");

    release_sync_a: assert property (
        ext_rel_s |-> ext_srst_n && !$past(ext_srst_n))
        else $error("reset release not two cycles");

    watchdog_keep_a: assert property (
        !ext_release |=> $stable(boot_8bit) && $stable(float_mode))
        else $error("strap modes changed without external reset");

    float_drive_a: assert property (
        float_mode |-> pad_oe == 32'h0000_0000 && !port_a_line_18_oe
        && !serial1_transmit_oe && !port_b_line_18_oe)
        else $error("driver enabled in float mode");

    float_enter_a: assert property (
        !ext_srst_n && output_float_strap ##1 ext_release
        |=> !float_mode)
        else $error("float entered with high strap");

    boot_latch_a: assert property (
        ext_release |=> boot_8bit == $past(boot_width_strap))
        else $error("boot width not latched at release");

    remap_sticky_a: assert property (
        remapped && chip_srst_n |=> remapped || !chip_srst_n)
        else $error("remap undone without reset");

    sram_cycle_a: assert property (
        sram_sel |=> mem_ack)
        else $error("internal memory not single cycle");
endmodule
`default_nettype wire

// ===== test/rsbad_board.sv
// Board model: reset source, strap resistors and debug probe
`timescale 1ns/100ps
`default_nettype none
module rsbad_board (
    // Clock from the bench
    input wire logic mclk,
    // Board reset and debug probe lines
    output logic external_reset_n,
    output logic test_logic_reset_n,
    output logic debug_port_select,
    // Strap pins
    output logic boot_width_strap,
    output logic output_float_strap
);
    // Held in reset, float strap pulled up, from time zero
    initial begin
        external_reset_n = 1'b0;
        test_logic_reset_n = 1'b0;
        debug_port_select = 1'b0;
        boot_width_strap = 1'b1;
        output_float_strap = 1'b1;
    end

    // Full chip reset with straps and debug select applied
    task automatic do_reset(input logic boot, input logic flt,
                            input logic sel);
        @(posedge mclk);
        external_reset_n <= 1'b0;
        test_logic_reset_n <= 1'b0;
        debug_port_select <= sel;
        boot_width_strap <= boot;
        output_float_strap <= flt;
        // Clock kept running well past ten cycles before release
        repeat (12) @(posedge mclk);
        external_reset_n <= 1'b1;
        test_logic_reset_n <= 1'b1;
        // Straps held through the latch edge, then reused as port lines
        repeat (3) @(posedge mclk);
        boot_width_strap <= ~boot;
        output_float_strap <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_rsbad_top.sv
// Self-checking bench for the reset, strap and address decode top
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %0t %s", $time, m); end end
module tb_rsbad_top;
    // ****************************************
    // Signals
    // ****************************************
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic watchdog_reset = 1'b0;
    logic remap_command_bit = 1'b0;
    logic req_a = 1'b1;
    logic req_s = 1'b1;
    logic req_b = 1'b1;
    logic [31:0] pad_oe_req = 32'hFFFF_FFFF;
    logic [31:0] addr = 32'h0000_0000;
    logic mem_req = 1'b0;
    logic mem_we = 1'b0;
    logic [3:0] mem_be = 4'h0;
    logic [31:0] mem_wdata = 32'h0000_0000;
    wire logic ext_n, tlr_n, sel, boot_s, flt_s;
    logic sys_reset_n, core_fetch_zero, boot_8bit, float_mode;
    logic debug_ice_mode, scan_has_idcode, oe_a, oe_s, oe_b;
    logic [31:0] pad_oe, mem_rdata;
    logic pio_input_default, remapped, boot_chip_select, sram_sel, mem_ack;
    rsbad_pkg::rsbad_region_type region;
    int fails = 0;
    int checked = 0;

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    rsbad_board board_u (.mclk(mclk), .external_reset_n(ext_n),
        .test_logic_reset_n(tlr_n), .debug_port_select(sel),
        .boot_width_strap(boot_s), .output_float_strap(flt_s));

    rsbad_top dut_u (.mclk(mclk), .rst(rst), .external_reset_n(ext_n),
        .watchdog_reset(watchdog_reset), .boot_width_strap(boot_s),
        .output_float_strap(flt_s), .debug_port_select(sel),
        .test_logic_reset_n(tlr_n), .remap_command_bit(remap_command_bit),
        .port_a_line_18_oe_req(req_a), .serial1_transmit_oe_req(req_s),
        .port_b_line_18_oe_req(req_b), .pad_oe_req(pad_oe_req),
        .addr(addr), .mem_req(mem_req), .mem_we(mem_we), .mem_be(mem_be),
        .mem_wdata(mem_wdata), .sys_reset_n(sys_reset_n),
        .core_fetch_zero(core_fetch_zero), .boot_8bit(boot_8bit),
        .float_mode(float_mode), .debug_ice_mode(debug_ice_mode),
        .scan_has_idcode(scan_has_idcode), .port_a_line_18_oe(oe_a),
        .serial1_transmit_oe(oe_s), .port_b_line_18_oe(oe_b),
        .pad_oe(pad_oe), .pio_input_default(pio_input_default),
        .remapped(remapped), .region(region),
        .boot_chip_select(boot_chip_select), .sram_sel(sram_sel),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    // ****************************************
    // Shared tasks
    // ****************************************
    // Counts, verdict and end of run
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Bounded wait for chip reset release, then one edge for straps
    task automatic wait_run();
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (sys_reset_n === 1'b1) break;
        end
        if (i == 40) begin
            fails++;
            $display("unexpected %0t no reset release", $time);
            conclude();
        end
        @(posedge mclk);
        #1;
    endtask

    // One memory cycle, ack and read data one cycle later
    task automatic mem_op(input logic [31:0] a, input logic w,
        input logic [3:0] be, input logic [31:0] d, input logic ack,
        input logic [31:0] rd);
        @(posedge mclk);
        addr <= a;
        mem_req <= 1'b1;
        mem_we <= w;
        mem_be <= be;
        mem_wdata <= d;
        @(posedge mclk);
        mem_req <= 1'b0;
        #1;
        `CHK(mem_ack, ack, "ack")
        if (ack && !w) `CHK(mem_rdata, rd, "rdata")
        @(posedge mclk);
        #1;
        `CHK(mem_ack, 1'b0, "ack stands")
    endtask

    // Decode of one held read request: boot select and SRAM select
    task automatic sel_chk(input logic [31:0] a, input logic cs,
        input logic ss);
        @(posedge mclk);
        addr <= a;
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        #1;
        `CHK(boot_chip_select, cs, "boot cs")
        `CHK(sram_sel, ss, "sram sel")
        @(posedge mclk);
        mem_req <= 1'b0;
    endtask

    // Strap and debug outcome after a reset
    task automatic chk_modes(input logic b, input logic f, input logic ice);
        `CHK(boot_8bit, b, "boot width")
        `CHK(float_mode, f, "float mode")
        `CHK(debug_ice_mode, ice, "debug mode")
        `CHK(scan_has_idcode, 1'b0, "idcode")
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Async entry, defaults, normal straps, pads pass after reset
    task automatic s_reset();
        fork
            board_u.do_reset(1'b1, 1'b1, 1'b0);
            begin
                @(posedge mclk);
                #1;
                `CHK(sys_reset_n, 1'b0, "async entry")
                `CHK(core_fetch_zero, 1'b1, "fetch zero")
                `CHK(pio_input_default, 1'b1, "inputs")
            end
        join
        wait_run();
        chk_modes(1'b1, 1'b0, 1'b1);
        `CHK(remapped, 1'b0, "remap default")
        `CHK(pad_oe, 32'hFFFF_FFFF, "pads")
        `CHK({oe_a, oe_s, oe_b}, 3'b111, "shared")
        `CHK(pio_input_default, 1'b0, "pio run")
        $display("s_reset done");
    endtask

    // Float and 16-bit straps, boundary scan select, pin entry with the clock running
    task automatic s_float();
        fork
            board_u.do_reset(1'b0, 1'b0, 1'b1);
            begin
                @(posedge mclk);
                #1;
                `CHK(sys_reset_n, 1'b0, "pin entry")
            end
        join
        wait_run();
        chk_modes(1'b0, 1'b1, 1'b0);
        `CHK(pad_oe, 32'h0000_0000, "float pads")
        `CHK({oe_a, oe_s, oe_b}, 3'b000, "float shared")
        $display("s_float done");
    endtask

    // Region decode, SRAM lanes and remap
    task automatic s_mem();
        logic [31:0] at [4];
        logic [1:0] rg [4];
        at = '{32'h0000_0000, 32'h0040_0000, 32'hFFBF_FFFF, 32'hFFC0_0000};
        rg = '{2'b00, 2'b01, 2'b01, 2'b11};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            addr <= at[i];
            #1;
            `CHK(region, rg[i], "region")
        end
        sel_chk(32'h0000_0000, 1'b0, 1'b0);
        mem_op(32'h0030_0000, 1'b1, 4'hF, 32'h4433_2211, 1'b1, 32'h0);
        mem_op(32'h0030_0000, 1'b1, 4'h2, 32'h0000_AA00, 1'b1, 32'h0);
        mem_op(32'h0030_0000, 1'b0, 4'hF, 32'h0, 1'b1, 32'h4433_AA11);
        mem_op(32'h0000_0000, 1'b0, 4'hF, 32'h0, 1'b0, 32'h0);
        mem_op(32'h0040_0000, 1'b0, 4'hF, 32'h0, 1'b0, 32'h0);
        @(posedge mclk);
        remap_command_bit <= 1'b1;
        @(posedge mclk);
        remap_command_bit <= 1'b0;
        #1;
        `CHK(remapped, 1'b1, "remap set")
        mem_op(32'h0000_0000, 1'b0, 4'hF, 32'h0, 1'b1, 32'h4433_AA11);
        sel_chk(32'h0000_0000, 1'b1, 1'b1);
        $display("s_mem done");
    endtask

    // Watchdog undoes remap, keeps straps
    task automatic s_wdog();
        @(posedge mclk);
        watchdog_reset <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(sys_reset_n, 1'b0, "wdog reset")
        @(posedge mclk);
        watchdog_reset <= 1'b0;
        wait_run();
        `CHK(remapped, 1'b0, "remap undone")
        chk_modes(1'b0, 1'b1, 1'b0);
        $display("s_wdog done");
    endtask

    // External reset during watchdog still samples straps
    task automatic s_both();
        @(posedge mclk);
        watchdog_reset <= 1'b1;
        fork
            board_u.do_reset(1'b1, 1'b1, 1'b0);
            begin
                // Watchdog still asserted as the pin is released
                repeat (14) @(posedge mclk);
                watchdog_reset <= 1'b0;
            end
        join
        wait_run();
        chk_modes(1'b1, 1'b0, 1'b1);
        $display("s_both done");
    endtask

    // Main sequence: block reset for two cycles, then scenarios
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        s_reset();
        s_float();
        s_mem();
        s_wdog();
        s_both();
        conclude();
    end
endmodule
`default_nettype wire
